// [src/hip_iso_status.v]
// high-speed isochronous descriptor microframe scheduling and write-back
// Notes on behaviour
// - an armed microframe of a matching frame gets its 12-bit count.
// - count 5 splits into bits 31..28 of word six and word seven.
// - count 2 splits into bits 3..0 of word six, 31..24 of word five.
// - counts 0 and 1 sit in word five, counts 3 and 4 in word six.
// - eight 3-bit results fill word four, bits 10..8 to 31..29.
// - result bit 0 flags a transaction error for both directions.
// - result bit 1 flags babble and is used for inbound transfers only.
// - result bit 2 flags underrun and is used for outbound transfers only.
// - active bits count only on a frame match; only armed ones issue.
// - software only sets active bits, hardware clears each when done.
// - active bit n arms microframe n, any pattern of bits works.
// - an engine halt sets the halt bit and clears the valid bit.
`timescale 1ns/1ps
`include "hip_defs.vh"

module hip_iso_status
#(
  parameter NUM_MF = 8
)
(
  input wire ref_clk,
  input wire rst_b,
  input wire [`HIP_ADDR_W-1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  output reg irq,
  input wire uframe_start,
  input wire [`HIP_FRAME_W-1:0] bus_frame_num,
  input wire [2:0] uframe_index,
  output reg iso_issue,
  output reg [2:0] iso_mf_index,
  output reg iso_token_in,
  input wire xact_done,
  input wire [`HIP_CNT_W-1:0] xact_byte_count,
  input wire xact_error,
  input wire xact_babble,
  input wire xact_underrun,
  input wire xact_halt
);

  // ***********************************************************
  // reset release
  // ***********************************************************
  // rst_sync is the only reset copy the rest of the block uses
  reg rst_meta;
  reg rst_sync;

  // async assert, two-flop release so all logic leaves reset together
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // ***********************************************************
  // descriptor and control state
  // ***********************************************************
  // two states suffice: at most one transaction is ever outstanding
  localparam ST_IDLE = 1'b0;
  localparam ST_WAIT = 1'b1;

  // descriptor fields kept in flops, shared by software and hardware
  reg state;
  reg [`HIP_FIELD_W-1:0] frame_field;
  reg desc_valid;
  reg desc_halt;
  reg [NUM_MF-1:0] microframe_active_mask;
  reg [`HIP_RES_W-1:0] mf_result [0:NUM_MF-1];
  reg [`HIP_CNT_W-1:0] mf_rx_byte_count [0:NUM_MF-1];
  reg [`HIP_EV_W-1:0] irq_sts;
  reg [`HIP_EV_W-1:0] irq_en;
  // one loop index per process, so each has a single writer
  integer wb_i;
  integer am_i;
  integer rd_i;

  // bus write commits only on the edge where the master sees waitrequest low
  wire wr_go = avs_write & ~avs_waitrequest;
  wire wr_frame = wr_go & (avs_address == `HIP_REG_FRAME);
  wire wr_ctrl = wr_go & (avs_address == `HIP_REG_CTRL);
  wire wr_result = wr_go & (avs_address == `HIP_REG_RESULT);
  wire wr_clr = wr_go & (avs_address == `HIP_REG_IRQ_CLR);
  wire wr_en = wr_go & (avs_address == `HIP_REG_IRQ_EN);
  wire wr_dir = wr_go & (avs_address == `HIP_REG_DIR);

  // frame compare on bits 7..3 only, low bits are don't care
  wire frame_match = (frame_field[`HIP_FRAME_SEL] == bus_frame_num);

  // start of an armed microframe in the programmed frame
  wire mf_armed = microframe_active_mask[uframe_index];
  wire start_ok = uframe_start & desc_valid & ~desc_halt & frame_match
                  & mf_armed;

  // an engine report only counts while a transaction is outstanding
  wire finish = (state == ST_WAIT) & xact_done;

  // ***********************************************************
  // result encoding
  // ***********************************************************
  // babble only means something inbound, underrun only outbound
  function [`HIP_RES_W-1:0] hip_encode;
    input err;
    input bab;
    input und;
    input dir_in;
    begin
      hip_encode = `HIP_ZERO3;
      hip_encode[`HIP_RES_ERR] = err;
      hip_encode[`HIP_RES_BABBLE] = bab & dir_in;
      hip_encode[`HIP_RES_UNDER] = und & ~dir_in;
    end
  endfunction

  // ***********************************************************
  // sequencer
  // ***********************************************************
  // one transaction in flight; further microframe starts are ignored
  // until the engine reports done, which the engine must guarantee
  always @(posedge ref_clk or negedge rst_sync)
  begin
    if (!rst_sync)
    begin
      state <= ST_IDLE;
      iso_issue <= 1'b0;
      iso_mf_index <= `HIP_ZERO3;
    end
    else
    begin
      // issue is a single-cycle pulse
      iso_issue <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          if (start_ok)
          begin
            iso_issue <= 1'b1;
            iso_mf_index <= uframe_index;
            state <= ST_WAIT;
          end
        end
        ST_WAIT:
        begin
          if (xact_done)
            state <= ST_IDLE;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // ***********************************************************
  // per-microframe write-back
  // ***********************************************************
  // only the microframe just processed is touched, others keep values
  always @(posedge ref_clk or negedge rst_sync)
  begin
    if (!rst_sync)
    begin
      for (wb_i = 0; wb_i < NUM_MF; wb_i = wb_i + 1)
      begin
        mf_result[wb_i] <= `HIP_ZERO3;
        mf_rx_byte_count[wb_i] <= `HIP_ZERO12;
      end
    end
    else if (finish)
    begin
      mf_rx_byte_count[iso_mf_index] <= xact_byte_count;
      mf_result[iso_mf_index] <= hip_encode(xact_error, xact_babble,
                                            xact_underrun,
                                            iso_token_in);
    end
  end

  // ***********************************************************
  // active mask: software sets, hardware clears after processing
  // ***********************************************************
  // a software set in the same cycle as the hardware clear wins,
  // since it is a fresh request for the next frame
  always @(posedge ref_clk or negedge rst_sync)
  begin
    if (!rst_sync)
      microframe_active_mask <= {NUM_MF{1'b0}};
    else
    begin
      for (am_i = 0; am_i < NUM_MF; am_i = am_i + 1)
      begin
        if (wr_result & avs_writedata[am_i])
          microframe_active_mask[am_i] <= 1'b1;
        else if (finish & (iso_mf_index == am_i[2:0]))
          microframe_active_mask[am_i] <= 1'b0;
      end
    end
  end

  // ***********************************************************
  // frame field, valid, halt, direction
  // ***********************************************************
  // halt stays set until software rewrites the control word
  always @(posedge ref_clk or negedge rst_sync)
  begin
    if (!rst_sync)
    begin
      frame_field <= `HIP_ZERO8;
      desc_valid <= 1'b0;
      desc_halt <= 1'b0;
      iso_token_in <= 1'b0;
    end
    else
    begin
      if (wr_frame)
        frame_field <= avs_writedata[`HIP_FIELD_W-1:0];
      if (wr_dir)
        iso_token_in <= avs_writedata[`HIP_DIR_IN_BIT];
      // hardware halt overrides a software write in the same cycle
      if (finish & xact_halt)
      begin
        desc_halt <= 1'b1;
        desc_valid <= 1'b0;
      end
      else if (wr_ctrl)
      begin
        desc_halt <= avs_writedata[`HIP_HALT_BIT];
        desc_valid <= avs_writedata[`HIP_VALID_BIT];
      end
    end
  end

  // ***********************************************************
  // interrupts
  // ***********************************************************
  // events pulse on the finishing edge only
  wire [`HIP_EV_W-1:0] ev;
  assign ev[`HIP_EV_DONE] = finish;
  assign ev[`HIP_EV_ERR] = finish & (xact_error | xact_babble
                                     | xact_underrun);
  assign ev[`HIP_EV_HALT] = finish & xact_halt;

  // sticky status, set wins over a clear in the same cycle;
  // irq is registered so it trails status by one clock
  always @(posedge ref_clk or negedge rst_sync)
  begin
    if (!rst_sync)
    begin
      irq_sts <= `HIP_ZERO3;
      irq_en <= `HIP_ZERO3;
      irq <= 1'b0;
    end
    else
    begin
      irq_sts <= (irq_sts & ~({`HIP_EV_W{wr_clr}}
                 & avs_writedata[`HIP_EV_W-1:0])) | ev;
      if (wr_en)
        irq_en <= avs_writedata[`HIP_EV_W-1:0];
      irq <= |(irq_sts & irq_en);
    end
  end

  // ***********************************************************
  // register read assembly
  // ***********************************************************
  // read words mirror the descriptor dword layout
  reg [31:0] rd_mux;
  reg [31:0] res_word;

  always @*
  begin
    res_word = `HIP_ZERO32;
    for (rd_i = 0; rd_i < NUM_MF; rd_i = rd_i + 1)
      res_word[`HIP_RES_BASE + `HIP_RES_W*rd_i +: `HIP_RES_W] =
        mf_result[rd_i];
    // low byte shows which microframes are still armed
    res_word[NUM_MF-1:0] = microframe_active_mask;
    case (avs_address)
      `HIP_REG_FRAME:
        rd_mux = {24'h000000, frame_field};
      `HIP_REG_CTRL:
        rd_mux = {desc_valid, desc_halt, 30'h0};
      `HIP_REG_RESULT:
        rd_mux = res_word;
      `HIP_REG_CNT_A:
        rd_mux = {mf_rx_byte_count[2][`HIP_SPLIT_LO8],
                  mf_rx_byte_count[1],
                  mf_rx_byte_count[0]};
      `HIP_REG_CNT_B:
        rd_mux = {mf_rx_byte_count[5][`HIP_SPLIT_LO4],
                  mf_rx_byte_count[4],
                  mf_rx_byte_count[3],
                  mf_rx_byte_count[2][`HIP_SPLIT_HI4]};
      `HIP_REG_CNT_C:
        rd_mux = {mf_rx_byte_count[7],
                  mf_rx_byte_count[6],
                  mf_rx_byte_count[5][`HIP_SPLIT_HI8]};
      `HIP_REG_IRQ_STS:
        rd_mux = {29'h0, irq_sts};
      `HIP_REG_IRQ_EN:
        rd_mux = {29'h0, irq_en};
      `HIP_REG_DIR:
        rd_mux = {31'h0, iso_token_in};
      // unmapped words and the clear register read as zero
      default:
        rd_mux = `HIP_ZERO32;
    endcase
  end

  // ***********************************************************
  // avalon slave handshake
  // ***********************************************************
  // fixed one wait cycle: waitrequest drops the edge after a request
  // arrives and rises again after the accepting edge
  always @(posedge ref_clk or negedge rst_sync)
  begin
    if (!rst_sync)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= `HIP_ZERO32;
    end
    else
    begin
      if ((avs_read | avs_write) & avs_waitrequest)
      begin
        avs_waitrequest <= 1'b0;
        avs_readdata <= rd_mux;
      end
      else
        avs_waitrequest <= 1'b1;
    end
  end

endmodule

// [src/hip_defs.vh]
// constants for the isochronous microframe status block
`ifndef HIP_DEFS_VH
`define HIP_DEFS_VH
// ***********************************************************
// register word addresses (avalon word addressing)
// ***********************************************************
`define HIP_ADDR_W 4
`define HIP_REG_FRAME 4'h0
`define HIP_REG_CTRL 4'h1
`define HIP_REG_RESULT 4'h2
`define HIP_REG_CNT_A 4'h3
`define HIP_REG_CNT_B 4'h4
`define HIP_REG_CNT_C 4'h5
`define HIP_REG_IRQ_STS 4'h6
`define HIP_REG_IRQ_CLR 4'h7
`define HIP_REG_IRQ_EN 4'h8
`define HIP_REG_DIR 4'h9
// ***********************************************************
// field layout
// ***********************************************************
`define HIP_VALID_BIT 31
`define HIP_HALT_BIT 30
`define HIP_FRAME_SEL 7:3
`define HIP_FRAME_W 5
`define HIP_FIELD_W 8
`define HIP_RES_BASE 8
`define HIP_RES_W 3
`define HIP_RES_ERR 0
`define HIP_RES_BABBLE 1
`define HIP_RES_UNDER 2
`define HIP_CNT_W 12
`define HIP_SPLIT_LO8 7:0
`define HIP_SPLIT_HI4 11:8
`define HIP_SPLIT_LO4 3:0
`define HIP_SPLIT_HI8 11:4
`define HIP_DIR_IN_BIT 0
// ***********************************************************
// interrupt events
// ***********************************************************
`define HIP_EV_W 3
`define HIP_EV_DONE 0
`define HIP_EV_ERR 1
`define HIP_EV_HALT 2
// ***********************************************************
// reset values
// ***********************************************************
`define HIP_ZERO32 32'h0000_0000
`define HIP_ZERO8 8'h00
`define HIP_ZERO3 3'h0
`define HIP_ZERO12 12'h000
`endif

// [verification/hip_iso_status_asserts.sv]
// assertion checker for the iso microframe status block
`timescale 1ns/1ps
module hip_iso_status_asserts (
  input wire ref_clk,
  input wire rst_b,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire uframe_start,
  input wire [4:0] bus_frame_num,
  input wire [2:0] uframe_index,
  input wire iso_issue,
  input wire [2:0] iso_mf_index,
  input wire iso_token_in,
  input wire xact_done
);
  reg [4:0] frame;
  reg busy;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // shadow frame field and outstanding flag, seen only through the ports
  always @(posedge ref_clk or negedge rst_b)
    if (!rst_b)
    begin
      frame <= 5'h00;
      busy <= 1'b0;
    end
    else
    begin
      if (avs_write && !avs_waitrequest && avs_address == 4'h0)
        frame <= avs_writedata[7:3];
      busy <= iso_issue || (busy && !xact_done);
    end
  property p_one_wait;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("bus answer late");
  property p_wait_pulse;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_pulse: assert property (p_wait_pulse) else $error("ready too long");
  property p_zero_read;
    avs_read && !avs_waitrequest
      && (avs_address == 4'h7 || avs_address > 4'h9)
      |-> avs_readdata == 32'h0;
  endproperty
  a_zero_read: assert property (p_zero_read) else $error("empty slot read");
  property p_issue_cause;
    iso_issue |-> $past(uframe_start)
      && $past(bus_frame_num) == $past(frame);
  endproperty
  a_issue_cause: assert property (p_issue_cause)
    else $error("stray issue");
  property p_issue_index;
    iso_issue |-> iso_mf_index == $past(uframe_index);
  endproperty
  a_issue_index: assert property (p_issue_index)
    else $error("wrong slot");
  property p_single;
    busy && !xact_done |=> !iso_issue;
  endproperty
  a_single: assert property (p_single)
    else $error("issue overlaps");
  property p_hold_index;
    !$stable(iso_mf_index) |-> iso_issue;
  endproperty
  a_hold_index: assert property (p_hold_index)
    else $error("index moved");
  property p_token;
    !$stable(iso_token_in) |-> $past(avs_write) || $past(avs_write, 2);
  endproperty
  a_token: assert property (p_token)
    else $error("token moved");
endmodule

bind hip_iso_status hip_iso_status_asserts u_asserts (.ref_clk(ref_clk),
  .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .uframe_start(uframe_start), .bus_frame_num(bus_frame_num),
  .uframe_index(uframe_index), .iso_issue(iso_issue),
  .iso_mf_index(iso_mf_index), .iso_token_in(iso_token_in),
  .xact_done(xact_done));

// [verification/hip_xact_model.sv]
// behavioural transaction engine answering each issue after a set delay
`timescale 1ns/1ps
module hip_xact_model (
  input wire ref_clk,
  input wire iso_issue,
  input wire [4:0] delay,
  input wire [11:0] count,
  input wire [3:0] flags,
  output logic xact_done,
  output logic [11:0] xact_byte_count,
  output logic [3:0] xact_res
);
  logic [4:0] left = 5'h00;
  initial {xact_done, xact_byte_count, xact_res} = 17'h0a5a5;
  // result lines scramble outside the pulse so nothing stale can pass
  always @(posedge ref_clk)
  begin
    xact_done <= 1'b0;
    xact_byte_count <= ~xact_byte_count;
    xact_res <= ~xact_res;
    if (iso_issue === 1'b1)
      left <= delay;
    else if (left == 5'h01)
    begin
      left <= 5'h00;
      xact_done <= 1'b1;
      xact_byte_count <= count;
      xact_res <= flags;
    end
    else if (left != 5'h00)
      left <= left - 5'h01;
  end
endmodule

// [verification/hip_iso_status_test.sv]
// self-checking bench for the iso microframe status block
`timescale 1ns/1ps
module hip_iso_status_test;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic uframe_start = 1'b0;
  logic [4:0] bus_frame_num = 5'h00;
  logic [2:0] uframe_index = 3'h0;
  logic [11:0] m_count = 12'h000;
  logic [3:0] m_flags = 4'h0;
  logic [4:0] m_delay = 5'h01;
  logic [4:0] fr = 5'h00;
  logic ev_err = 1'b0;
  logic [11:0] e_cnt [8] = '{default: 12'h000};
  logic [2:0] e_res [8] = '{default: 3'h0};
  logic [31:0] q_rd [$];
  logic [2:0] q_mf [$];
  int fail_count = 0;
  int n_compared = 0;
  int cyc = 0;
  wire [31:0] avs_readdata;
  wire [11:0] xact_byte_count;
  wire [3:0] xr;
  wire [2:0] iso_mf_index;
  wire avs_waitrequest, irq, iso_issue, iso_token_in, xact_done;

  hip_iso_status uut (.ref_clk(ref_clk), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq),
    .uframe_start(uframe_start), .bus_frame_num(bus_frame_num),
    .uframe_index(uframe_index), .iso_issue(iso_issue),
    .iso_mf_index(iso_mf_index), .iso_token_in(iso_token_in),
    .xact_done(xact_done), .xact_byte_count(xact_byte_count),
    .xact_error(xr[0]), .xact_babble(xr[1]), .xact_underrun(xr[2]),
    .xact_halt(xr[3]));
  hip_xact_model u_eng (.ref_clk(ref_clk), .iso_issue(iso_issue),
    .delay(m_delay), .count(m_count), .flags(m_flags),
    .xact_done(xact_done), .xact_byte_count(xact_byte_count),
    .xact_res(xr));

  always #5 ref_clk = ~ref_clk;

  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // one idle edge first, so a release never meets a new request
  task automatic bus(input logic w, input logic [3:0] a,
    input logic [31:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    q_rd.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic mf(input logic [2:0] i, input logic [4:0] f,
    input logic armed);
    @(posedge ref_clk);
    if (armed) q_mf.push_back(i);
    uframe_start <= 1'b1;
    uframe_index <= i;
    bus_frame_num <= f;
    @(posedge ref_clk);
    uframe_start <= 1'b0;
    repeat (armed ? 0 : 6) @(posedge ref_clk);
    while (armed && xact_done !== 1'b1) @(posedge ref_clk);
  endtask

  task automatic check_all(input logic [7:0] act);
    rd(4'h2, {e_res[7], e_res[6], e_res[5], e_res[4], e_res[3], e_res[2],
      e_res[1], e_res[0], act});
    rd(4'h3, {e_cnt[2][7:0], e_cnt[1], e_cnt[0]});
    rd(4'h4, {e_cnt[5][3:0], e_cnt[4], e_cnt[3], e_cnt[2][11:8]});
    rd(4'h5, {e_cnt[7], e_cnt[6], e_cnt[5][11:4]});
  endtask

  // every armed slot gets fresh counts and flags, fast and slow answers
  task automatic pass(input logic [7:0] mask, input logic din);
    logic [11:0] c;
    logic [3:0] fl;
    int i;
    bus(1'b1, 4'h9, {31'h0, din});
    rd(4'h9, {31'h0, din});
    chk("token", {31'h0, din}, {31'h0, iso_token_in});
    bus(1'b1, 4'h2, {24'h0, mask});
    for (i = 0; i < 8; i++)
    begin
      c = 12'($urandom);
      fl = 4'($urandom) & 4'h7;
      m_count <= c;
      m_flags <= fl;
      m_delay <= i[0] ? 5'h01 : 5'h01 + 5'($urandom % 20);
      if (mask[i])
      begin
        e_cnt[i] = c;
        if (fl != 4'h0)
          ev_err = 1'b1;
        e_res[i] = din ? {1'b0, fl[1:0]} : {fl[2], 1'b0, fl[0]};
      end
      mf(i[2:0], fr, mask[i]);
    end
    check_all(8'h00);
  endtask

  // monitor: pair every read answer and every issue with its note
  always @(posedge ref_clk)
  begin
    cyc++;
    if (avs_read && avs_waitrequest === 1'b0)
      chk("readdata", q_rd.pop_front(), avs_readdata);
    if (iso_issue !== 1'b0)
      chk("issue", q_mf.size() ? {29'h0, q_mf.pop_front()} : 32'hffff_ffff,
        {29'h0, iso_mf_index});
    if (cyc == 20000)
    begin
      fail_count++;
      give_verdict();
    end
  end

  initial
  begin
    void'($urandom(79));
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge ref_clk);
    fr = 5'($urandom);
    rd(4'h1, 32'h0);
    bus(1'b1, 4'h8, 32'h0000_0007);
    bus(1'b1, 4'h0, {24'h0, fr, 3'h5});
    bus(1'b1, 4'h1, 32'h8000_0000);
    pass(8'h55, 1'b1);
    pass(8'haa, 1'b0);
    pass(8'hff, 1'b1);
    @(posedge ref_clk);
    chk("irq", 32'h1, {31'h0, irq});
    rd(4'h6, {29'h0, 1'b0, ev_err, 1'b1});
    bus(1'b1, 4'h7, 32'h0000_0007);
    repeat (3) @(posedge ref_clk);
    chk("irq", 32'h0, {31'h0, irq});
    rd(4'h6, 32'h0);
    bus(1'b1, 4'h2, 32'h0000_0008);
    bus(1'b1, 4'h2, 32'h0);
    mf(3'h3, fr ^ 5'h01, 1'b0);
    check_all(8'h08);
    rd(4'hf, 32'h0);
    rd(4'h7, 32'h0);
    m_flags <= 4'h8;
    m_delay <= 5'h01;
    mf(3'h3, fr, 1'b1);
    rd(4'h1, 32'h4000_0000);
    rd(4'h6, 32'h0000_0005);
    give_verdict();
  end
endmodule
